// >>> logic/bias_bank_defines.svh
// Purpose: offsets, field positions, reset values and counts of the bias bank
// Assumes: included by bare name from the package and the design modules
// Notes:   every figure of the register map lives here once
`ifndef BIAS_BANK_DEFINES_SVH
`define BIAS_BANK_DEFINES_SVH

// ----------------------------------------------------------------------------
// register offsets
// ----------------------------------------------------------------------------
`define ADDR_W                5
`define OFS_SYSTEM_CONTROL    5'h00
`define OFS_CARRIER_SENSE     5'h01
`define OFS_CARRIER_DRIVER    5'h02
`define OFS_CARRIER_FINAL     5'h03
`define OFS_PEAKING_SENSE     5'h04
`define OFS_PEAKING_DRIVER    5'h05
`define OFS_PEAKING_FINAL     5'h06
`define OFS_TEMPERATURE       5'h0f
`define OFS_UNLOCK_CODE       5'h11

// ----------------------------------------------------------------------------
// system control fields
// ----------------------------------------------------------------------------
`define SYS_SOFT_RESET_BIT    6
`define SYS_REFRESH_BIT       5
`define SYS_VERSION_MSB       3

// ----------------------------------------------------------------------------
// values and counts
// ----------------------------------------------------------------------------
`define UNLOCK_PASSCODE       8'he3
`define SENSE_MASK            8'h3f
`define SENSE_RESET_VALUE     8'h20
`define BIAS_RESET_VALUE      8'h80
`define BIAS_COUNT            6
`define BIAS_LAST_INDEX       3'h5
`define CARRIER_SENSE_INDEX   3'h0
`define PEAKING_SENSE_INDEX   3'h3

`endif

// >>> logic/bias_bank_pkg.sv
// Purpose: types shared by the bias register bank
// Assumes: bias_bank_defines.svh holds the figures
// Notes:   the whole bank state is one packed struct
`include "bias_bank_defines.svh"

package bias_bank_pkg;

   typedef logic [`ADDR_W-1:0] reg_addr_t;
   typedef logic [7:0]         reg_byte_t;

   // gray along idle -> load -> capture
   typedef enum logic [1:0] {
      ST_IDLE = 2'b00,
      ST_LOAD = 2'b01,
      ST_CAPT = 2'b11
   } load_state_t;

   typedef struct packed {
      load_state_t                        state;
      logic [2:0]                         idx;
      logic [`BIAS_COUNT-1:0][7:0]        bias;
      logic                               eng_mode;
      logic                               soft_reset;
      logic                               refresh;
      reg_byte_t                          rd_data;
      logic                               rd_valid;
      reg_byte_t                          temp_s1;
      reg_byte_t                          temp_s2;
   } bank_state_t;

endpackage : bias_bank_pkg

// >>> logic/otp_store.sv
// Purpose: factory one-time-programmable store of the six bias values
// Assumes: contents fixed at build time, no write path of any kind
// Notes:   read data come out of a register one enabled edge after rd_en
`timescale 1ns/10ps
`include "bias_bank_defines.svh"

module otp_store #(
   parameter logic [`BIAS_COUNT-1:0][7:0] CONTENTS = {
      `BIAS_RESET_VALUE, `BIAS_RESET_VALUE, `SENSE_RESET_VALUE,
      `BIAS_RESET_VALUE, `BIAS_RESET_VALUE, `SENSE_RESET_VALUE}
) (
   // clock and reset
   input  wire logic       clk_sys,
   input  wire logic       reset,
   input  wire logic       clk_en,
   // read port only: the array cannot be altered from outside
   input  wire logic       rd_en,
   input  wire logic [2:0] rd_addr,
   output logic      [7:0] rd_data
);

   always_ff @(posedge clk_sys or posedge reset) begin
      if (reset) begin
         rd_data <= 8'h00;
      end else if (clk_en && rd_en) begin
         rd_data <= CONTENTS[rd_addr];
      end
   end

endmodule : otp_store

// >>> logic/bias_register_bank.sv
// Purpose: user register bank with factory bias load and override unlock
// Assumes: host port logic runs on clk_sys; temperature comes from elsewhere
// Notes:   a read answers one enabled edge later with rd_valid
//
// Summary of operation
// - after power-up or any reset the six bias registers load from the otp.
// - host writes to the bias registers count only in override mode.
// - override values are lost at reset, and the factory values come back.
// - the otp array has no write path at all.
// - nine user registers, each eight bits wide.
// - address 0 holds soft reset, otp refresh and the version field.
// - addresses 1 to 6 are read-write, otp loaded and drive the bias dacs.
// - address 15 reads back the eight-bit temperature reading.
// - writing e3 hex to write-only address 17 enters override mode.
// - a one in control bit 6 clears override mode and sets the bias registers to defaults, then reloads the otp.
// - a one in control bit 5 reloads the factory values from the otp.
// - control bits 3 to 0 show a fixed version that writes cannot change.
// - the sense registers hold six bits, the upper two read zero.
`timescale 1ns/10ps
`include "bias_bank_defines.svh"

module bias_register_bank
   import bias_bank_pkg::*;
#(
   // arbitrary neutral revision value
   parameter logic [3:0]                  VERSION      = 4'h5,
   parameter logic [`BIAS_COUNT-1:0][7:0] OTP_CONTENTS = {
      `BIAS_RESET_VALUE, `BIAS_RESET_VALUE, `SENSE_RESET_VALUE,
      `BIAS_RESET_VALUE, `BIAS_RESET_VALUE, `SENSE_RESET_VALUE}
) (
   // clock, reset, enable
   input  wire logic                  clk_sys,
   input  wire logic                  reset,
   input  wire logic                  clk_en,
   // register port from the serial control logic
   input  wire logic                  wr_en,
   input  wire logic                  rd_en,
   input  wire bias_bank_pkg::reg_addr_t addr,
   input  wire bias_bank_pkg::reg_byte_t wr_data,
   output bias_bank_pkg::reg_byte_t   rd_data,
   output logic                       rd_valid,
   // temperature sensor byte, asynchronous to clk_sys
   input  wire bias_bank_pkg::reg_byte_t temp_sense,
   // bias dac settings
   output bias_bank_pkg::reg_byte_t   carrier_sense_reference,
   output bias_bank_pkg::reg_byte_t   carrier_driver_bias,
   output bias_bank_pkg::reg_byte_t   carrier_final_bias,
   output bias_bank_pkg::reg_byte_t   peaking_sense_reference,
   output bias_bank_pkg::reg_byte_t   peaking_driver_bias,
   output bias_bank_pkg::reg_byte_t   peaking_final_bias,
   // status
   output logic                       engineering_override_mode,
   output logic                       otp_load_busy
);

   import bias_bank_pkg::*;

   // -------------------------------------------------------------------------
   // constants
   // -------------------------------------------------------------------------
   localparam logic [`BIAS_COUNT-1:0][7:0] BIAS_DEFAULTS = {
      `BIAS_RESET_VALUE, `BIAS_RESET_VALUE, `SENSE_RESET_VALUE,
      `BIAS_RESET_VALUE, `BIAS_RESET_VALUE, `SENSE_RESET_VALUE};

   // reset starts in load so the factory values arrive without host help
   localparam bank_state_t RESET_STATE = '{
      state      : ST_LOAD,
      idx        : 3'h0,
      bias       : BIAS_DEFAULTS,
      eng_mode   : 1'b0,
      soft_reset : 1'b0,
      refresh    : 1'b0,
      rd_data    : 8'h00,
      rd_valid   : 1'b0,
      temp_s1    : 8'h00,
      temp_s2    : 8'h00
   };

   // -------------------------------------------------------------------------
   // state
   // -------------------------------------------------------------------------
   bank_state_t r;
   bank_state_t n;
   reg_byte_t   otp_data;
   logic        otp_rd_en;

   // sense registers keep six bits only
   function automatic reg_byte_t fit_value(input logic [2:0] idx,
                                           input reg_byte_t  value);
      if (idx == `CARRIER_SENSE_INDEX || idx == `PEAKING_SENSE_INDEX) begin
         return value & `SENSE_MASK;
      end
      return value;
   endfunction : fit_value

   // -------------------------------------------------------------------------
   // factory store
   // -------------------------------------------------------------------------
   assign otp_rd_en = (r.state == ST_LOAD);

   otp_store #(
      .CONTENTS (OTP_CONTENTS)
   ) u_otp (
      .clk_sys (clk_sys),
      .reset   (reset),
      .clk_en  (clk_en),
      .rd_en   (otp_rd_en),
      .rd_addr (r.idx),
      .rd_data (otp_data)
   );

   // -------------------------------------------------------------------------
   // next state
   // -------------------------------------------------------------------------
   always_comb begin
      logic [2:0] widx;
      widx       = addr[2:0] - 3'h1;
      n          = r;
      n.rd_valid = 1'b0;
      // first stage feeds only the second one
      n.temp_s1  = temp_sense;
      n.temp_s2  = r.temp_s1;

      // otp copy: issue a read, then capture it one edge later
      unique case (r.state)
         ST_IDLE: begin
            n.state = ST_IDLE;
         end
         ST_LOAD: begin
            n.state = ST_CAPT;
         end
         ST_CAPT: begin
            n.bias[r.idx] = fit_value(r.idx, otp_data);
            if (r.idx == `BIAS_LAST_INDEX) begin
               n.state = ST_IDLE;
            end else begin
               n.idx   = r.idx + 3'h1;
               n.state = ST_LOAD;
            end
         end
         default: begin
            n.state = ST_LOAD;
            n.idx   = 3'h0;
         end
      endcase

      // reads: unlisted addresses answer zero
      if (rd_en) begin
         n.rd_valid = 1'b1;
         unique case (addr)
            `OFS_SYSTEM_CONTROL: begin
               n.rd_data = {1'b0, r.soft_reset, r.refresh, 1'b0,
                            VERSION};
            end
            `OFS_CARRIER_SENSE, `OFS_CARRIER_DRIVER, `OFS_CARRIER_FINAL,
            `OFS_PEAKING_SENSE, `OFS_PEAKING_DRIVER, `OFS_PEAKING_FINAL: begin
               n.rd_data = r.bias[widx];
            end
            `OFS_TEMPERATURE: begin
               n.rd_data = r.temp_s2;
            end
            default: begin
               n.rd_data = 8'h00;
            end
         endcase
      end

      // writes; the unlock location reads back zero like a reserved one
      if (wr_en) begin
         unique case (addr)
            `OFS_SYSTEM_CONTROL: begin
               n.soft_reset = wr_data[`SYS_SOFT_RESET_BIT];
               n.refresh    = wr_data[`SYS_REFRESH_BIT];
               if (wr_data[`SYS_SOFT_RESET_BIT]) begin
                  // defaults first, then the factory copy follows
                  n.bias     = BIAS_DEFAULTS;
                  n.eng_mode = 1'b0;
                  n.idx      = 3'h0;
                  n.state    = ST_LOAD;
               end else if (wr_data[`SYS_REFRESH_BIT]) begin
                  n.idx   = 3'h0;
                  n.state = ST_LOAD;
               end
            end
            `OFS_CARRIER_SENSE, `OFS_CARRIER_DRIVER, `OFS_CARRIER_FINAL,
            `OFS_PEAKING_SENSE, `OFS_PEAKING_DRIVER, `OFS_PEAKING_FINAL: begin
               // a running copy would overwrite the value, so drop it
               if (r.eng_mode && r.state == ST_IDLE) begin
                  n.bias[widx] = fit_value(widx, wr_data);
               end
            end
            `OFS_UNLOCK_CODE: begin
               if (wr_data == `UNLOCK_PASSCODE) begin
                  n.eng_mode = 1'b1;
               end
            end
            default: begin
               n.eng_mode = n.eng_mode;
            end
         endcase
      end
   end

   // -------------------------------------------------------------------------
   // register
   // -------------------------------------------------------------------------
   always_ff @(posedge clk_sys or posedge reset) begin
      if (reset) begin
         r <= RESET_STATE;
      end else if (clk_en) begin
         r <= n;
      end
   end

   // -------------------------------------------------------------------------
   // outputs, all straight from the state register
   // -------------------------------------------------------------------------
   assign rd_data                   = r.rd_data;
   assign rd_valid                  = r.rd_valid;
   assign carrier_sense_reference   = r.bias[0];
   assign carrier_driver_bias       = r.bias[1];
   assign carrier_final_bias        = r.bias[2];
   assign peaking_sense_reference   = r.bias[3];
   assign peaking_driver_bias       = r.bias[4];
   assign peaking_final_bias        = r.bias[5];
   assign engineering_override_mode = r.eng_mode;
   // load and capture both carry bit 0, so busy is a bare state flop
   assign otp_load_busy             = r.state[0];

endmodule : bias_register_bank

// >>> testbench/bias_bank_props.sv
// Purpose: concurrent checks on the ports of the bias register bank
// Assumes: clk_en held high by the bench
// Notes:   bound to every bias_register_bank instance
`timescale 1ns/10ps
`include "bias_bank_defines.svh"

module bias_bank_props
   import bias_bank_pkg::*;
(
   // clock and reset
   input wire logic      clk_sys,
   input wire logic      reset,
   input wire logic      clk_en,
   // register port
   input wire logic      wr_en,
   input wire logic      rd_en,
   input wire reg_addr_t addr,
   input wire reg_byte_t wr_data,
   input wire reg_byte_t rd_data,
   input wire logic      rd_valid,
   input wire reg_byte_t temp_sense,
   // outputs
   input wire reg_byte_t carrier_sense_reference,
   input wire reg_byte_t carrier_driver_bias,
   input wire reg_byte_t peaking_sense_reference,
   input wire logic      engineering_override_mode,
   input wire logic      otp_load_busy
);
   default clocking @(posedge clk_sys); endclocking
   default disable iff (reset);
   wire wr_go = wr_en && clk_en;
   wire rd_go = rd_en && clk_en;
   wire mode  = engineering_override_mode;
   wire bias2 = wr_go && addr == `OFS_CARRIER_DRIVER && !otp_load_busy;

   chk_read_answer: assert property (rd_go |=> rd_valid)
      else $error("read not answered");
   chk_reserved_zero: assert property (
      rd_go && addr inside {[7:14], 16} |=> rd_data == 8'h00)
      else $error("reserved read not zero");
   chk_temp_read: assert property (
      rd_go && addr == `OFS_TEMPERATURE && temp_sense == $past(temp_sense, 4)
      |=> rd_data == $past(temp_sense))
      else $error("temperature read wrong");
   chk_sense_bits: assert property (
      carrier_sense_reference[7:6] == 2'b00
      && peaking_sense_reference[7:6] == 2'b00)
      else $error("sense upper bits set");
   chk_unlock_enter: assert property (
      wr_go && addr == `OFS_UNLOCK_CODE && wr_data == `UNLOCK_PASSCODE
      |=> mode) else $error("unlock code not taken");
   chk_locked_bias: assert property (
      !mode && bias2 |=> $stable(carrier_driver_bias))
      else $error("locked write took");
   chk_override_write: assert property (
      mode && bias2 |=> carrier_driver_bias == $past(wr_data))
      else $error("override write lost");
   chk_soft_clear: assert property (
      wr_go && addr == 0 && wr_data[6]
      |=> !mode && otp_load_busy && carrier_driver_bias == `BIAS_RESET_VALUE)
      else $error("soft reset not applied");
   chk_refresh_keep: assert property (
      wr_go && addr == 0 && wr_data[6:5] == 2'b01
      |=> otp_load_busy && mode == $past(mode))
      else $error("refresh not applied");
   // twelve busy samples: six entries, each a load edge and a capture edge
   chk_load_length: assert property (
      $fell(reset) |-> otp_load_busy[*8] ##1 otp_load_busy[*4]
      ##1 !otp_load_busy) else $error("factory load length wrong");

   cov_unlock: cover property (wr_go && addr == `OFS_UNLOCK_CODE ##1 mode);
   cov_refresh: cover property (wr_go && addr == 0 && wr_data[5]);
   cov_temp: cover property (rd_go && addr == `OFS_TEMPERATURE);
endmodule : bias_bank_props

bind bias_register_bank bias_bank_props props (
   .clk_sys                   (clk_sys),
   .reset                     (reset),
   .clk_en                    (clk_en),
   .wr_en                     (wr_en),
   .rd_en                     (rd_en),
   .addr                      (addr),
   .wr_data                   (wr_data),
   .rd_data                   (rd_data),
   .rd_valid                  (rd_valid),
   .temp_sense                (temp_sense),
   .carrier_sense_reference   (carrier_sense_reference),
   .carrier_driver_bias       (carrier_driver_bias),
   .peaking_sense_reference   (peaking_sense_reference),
   .engineering_override_mode (engineering_override_mode),
   .otp_load_busy             (otp_load_busy)
);

// >>> testbench/host_port_model.sv
// Purpose: host side of the register port, single byte requests
// Assumes: requests change 2 ns after a rising clk_sys edge
// Notes:   idle address and data show the inverse of the last value
`timescale 1ns/10ps

module host_port_model
   import bias_bank_pkg::*;
(
   // clock
   input  wire logic clk_sys,
   // requests
   output logic      wr_en,
   output logic      rd_en,
   output reg_addr_t addr,
   output reg_byte_t wr_data,
   // answers
   input  wire reg_byte_t rd_data,
   input  wire logic      rd_valid
);
   initial {wr_en, rd_en, addr, wr_data} = '0;

   task automatic wr_reg(input reg_addr_t a, input reg_byte_t d);
      @(posedge clk_sys) #2;
      {wr_en, addr, wr_data} = {1'b1, a, d};
      @(posedge clk_sys) #2;
      {wr_en, addr, wr_data} = {1'b0, ~a, ~d};
   endtask : wr_reg

   // d stays unknown when no answer arrives within the bound
   task automatic rd_reg(input reg_addr_t a, output reg_byte_t d,
                         output logic ok);
      {ok, d} = {1'b0, 8'hxx};
      @(posedge clk_sys) #2;
      {rd_en, addr} = {1'b1, a};
      @(posedge clk_sys) #2;
      {rd_en, addr} = {1'b0, ~a};
      for (int i = 0; i < 4 && !ok; i++) begin
         if (rd_valid === 1'b1) {ok, d} = {1'b1, rd_data};
         else @(posedge clk_sys) #2;
      end
   endtask : rd_reg
endmodule : host_port_model

// >>> testbench/bias_register_bank_tb.sv
// Purpose: register level regression of the bias register bank
// Assumes: clk_en tied high, distinct factory values for every entry
// Notes:   bias outputs are compared together with their readback
`timescale 1ns/10ps
`include "bias_bank_defines.svh"

module bias_register_bank_tb;
   import bias_bank_pkg::*;
   // arbitrary revision value
   localparam logic [3:0] VER = 4'h9;
   localparam logic [5:0][7:0] OTP = {8'h66, 8'h55, 8'h14, 8'h33, 8'h22, 8'h11};
   logic            clk_sys = 0, reset = 1, wr_en, rd_en, rd_valid, mode, busy;
   reg_addr_t       addr;
   reg_byte_t       wr_data, rd_data, temp_sense = 8'h00;
   wire logic [5:0][7:0] dac;
   logic [5:0][7:0] ovr;
   int              bad_count = 0, checks = 0;

   initial forever #25 clk_sys = ~clk_sys;

   host_port_model host (.clk_sys(clk_sys), .wr_en(wr_en), .rd_en(rd_en),
      .addr(addr), .wr_data(wr_data), .rd_data(rd_data), .rd_valid(rd_valid));
   bias_register_bank #(.VERSION(VER), .OTP_CONTENTS(OTP)) DUT (
      .clk_sys(clk_sys), .reset(reset), .clk_en(1'b1), .wr_en(wr_en),
      .rd_en(rd_en), .addr(addr), .wr_data(wr_data), .rd_data(rd_data),
      .rd_valid(rd_valid), .temp_sense(temp_sense),
      .carrier_sense_reference(dac[0]), .carrier_driver_bias(dac[1]),
      .carrier_final_bias(dac[2]), .peaking_sense_reference(dac[3]),
      .peaking_driver_bias(dac[4]), .peaking_final_bias(dac[5]),
      .engineering_override_mode(mode), .otp_load_busy(busy));

   task automatic finish_test();
      $display("checks %0d bad %0d", checks, bad_count);
      if (bad_count == 0 && checks > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask : finish_test

   task automatic check(input string what, input reg_byte_t seen, exp);
      checks++;
      if (seen !== exp) begin
         bad_count++;
         $display("BAD %s expected %h seen %h", what, exp, seen);
      end
   endtask : check

   task automatic rd_chk(input reg_addr_t a, input reg_byte_t exp);
      reg_byte_t d;
      logic      ok;
      host.rd_reg(a, d, ok);
      check($sformatf("read %0d", a), d, exp);
      if (!ok) finish_test();
   endtask : rd_chk

   task automatic wait_idle();
      for (int i = 0; busy !== 1'b0; i++) begin
         if (i == 40) begin
            check("load timeout", 8'h01, 8'h00);
            finish_test();
         end
         @(posedge clk_sys) #2;
      end
   endtask : wait_idle

   task automatic bank_chk(input logic [5:0][7:0] e);
      for (int i = 0; i < 6; i++) begin
         rd_chk(reg_addr_t'(i + 1), e[i]);
         check("dac", dac[i], e[i]);
      end
   endtask : bank_chk

   // -------------------------------------------------------------------
   // main sequence
   // -------------------------------------------------------------------
   initial begin
      repeat (6) @(posedge clk_sys);
      #2 reset = 0;
      wait_idle();
      bank_chk(OTP);
      rd_chk(`OFS_SYSTEM_CONTROL, {4'h0, VER});
      host.wr_reg(`OFS_SYSTEM_CONTROL, 8'h0f);
      rd_chk(`OFS_SYSTEM_CONTROL, {4'h0, VER});
      $display("test factory load done");
      host.wr_reg(`OFS_CARRIER_DRIVER, 8'haa);
      rd_chk(`OFS_CARRIER_DRIVER, OTP[1]);
      host.wr_reg(`OFS_UNLOCK_CODE, 8'he2);
      check("mode", {7'h0, mode}, 8'h00);
      host.wr_reg(`OFS_UNLOCK_CODE, `UNLOCK_PASSCODE);
      check("mode", {7'h0, mode}, 8'h01);
      for (int i = 0; i < 6; i++) begin
         ovr[i] = 8'hc0 + 8'(i);
         host.wr_reg(reg_addr_t'(i + 1), ovr[i]);
         if (i == 0 || i == 3) ovr[i] &= `SENSE_MASK;
      end
      bank_chk(ovr);
      rd_chk(`OFS_UNLOCK_CODE, 8'h00);
      $display("test override done");
      temp_sense = 8'h5a;
      for (int a = 7; a <= 16; a++) begin
         host.wr_reg(reg_addr_t'(a), 8'hff);
         rd_chk(reg_addr_t'(a), (a == 15) ? 8'h5a : 8'h00);
      end
      $display("test reserved and temperature done");
      host.wr_reg(`OFS_SYSTEM_CONTROL, 8'h20);
      check("busy", {7'h0, busy}, 8'h01);
      wait_idle();
      bank_chk(OTP);
      check("mode", {7'h0, mode}, 8'h01);
      rd_chk(`OFS_SYSTEM_CONTROL, {4'h2, VER});
      host.wr_reg(`OFS_SYSTEM_CONTROL, 8'h00);
      $display("test refresh done");
      host.wr_reg(`OFS_CARRIER_FINAL, 8'h99);
      host.wr_reg(`OFS_SYSTEM_CONTROL, 8'h40);
      check("mode", {7'h0, mode}, 8'h00);
      wait_idle();
      bank_chk(OTP);
      rd_chk(`OFS_SYSTEM_CONTROL, {4'h4, VER});
      host.wr_reg(`OFS_SYSTEM_CONTROL, 8'h00);
      $display("test soft reset done");
      host.wr_reg(`OFS_UNLOCK_CODE, `UNLOCK_PASSCODE);
      host.wr_reg(`OFS_CARRIER_DRIVER, 8'h5c);
      rd_chk(`OFS_CARRIER_DRIVER, 8'h5c);
      @(posedge clk_sys) #2 reset = 1;
      @(posedge clk_sys) #2 reset = 0;
      wait_idle();
      check("mode", {7'h0, mode}, 8'h00);
      bank_chk(OTP);
      $display("test hard reset done");
      finish_test();
   end
endmodule : bias_register_bank_tb
